// *** verilog/lead_off_defs.svh ***
`ifndef LEAD_OFF_DEFS_SVH
`define LEAD_OFF_DEFS_SVH

`define LO_OFS_POS_ENABLE 8'h0f
`define LO_OFS_NEG_ENABLE 8'h10
`define LO_OFS_POLARITY 8'h11
`define LO_OFS_POS_STATUS 8'h12
`define LO_OFS_NEG_STATUS 8'h13
`define LO_OFS_IRQ_STATUS 8'h20
`define LO_OFS_IRQ_MASK 8'h21
`define LO_OFS_VARIANT 8'h22
`define LO_RST_REG 8'h00
`define LO_RST_VARIANT 2'h2
`define LO_MASK_4CH 8'h0f
`define LO_MASK_6CH 8'h3f
`define LO_MASK_8CH 8'hff
`define LO_IRQ_POS_BIT 0
`define LO_IRQ_NEG_BIT 1

`endif

// *** verilog/lead_off_pkg.sv ***
`default_nettype none
package lead_off_pkg;
  typedef logic [7:0] chan_vec_t;
  typedef enum logic [1:0] {
    VAR_4CH = 2'h0,
    VAR_6CH = 2'h1,
    VAR_8CH = 2'h2
  } variant_t;
endpackage : lead_off_pkg
`default_nettype wire

// *** verilog/pin_sync3.sv ***
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [7:0] i_async,
  output logic [7:0] o_stable
);
  logic [7:0] s1_ff;
  logic [7:0] s2_ff;
  logic [7:0] s3_ff;

  // A bit changes only when the second and third stages agree
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
          s1_ff[g] <= 1'b0;
          s2_ff[g] <= 1'b0;
          s3_ff[g] <= 1'b0;
          o_stable[g] <= 1'b0;
        end else begin
          s1_ff[g] <= i_async[g];
          s2_ff[g] <= s1_ff[g];
          s3_ff[g] <= s2_ff[g];
          if (s2_ff[g] == s3_ff[g]) begin
            o_stable[g] <= s3_ff[g];
          end
        end
      end
    end
  endgenerate
endmodule : pin_sync3
`default_nettype wire

// *** verilog/lead_off_register_bank.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "lead_off_defs.svh"
module lead_off_register_bank (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [1:0] i_variant,
  input wire logic [7:0] i_pos_comp_off,
  input wire logic [7:0] i_neg_comp_off,
  output logic [7:0] o_rdata,
  output logic [7:0] o_pos_excite_en,
  output logic [7:0] o_neg_excite_en,
  output logic [7:0] o_pos_pull_up,
  output logic [7:0] o_pos_pull_down,
  output logic [7:0] o_neg_pull_up,
  output logic [7:0] o_neg_pull_down,
  output logic o_irq
);
  lead_off_pkg::chan_vec_t positive_detect_enables_ff;
  lead_off_pkg::chan_vec_t negative_detect_enables_ff;
  lead_off_pkg::chan_vec_t excitation_polarity_bits_ff;
  lead_off_pkg::chan_vec_t positive_electrode_off_status_ff;
  lead_off_pkg::chan_vec_t negative_electrode_off_status_ff;
  lead_off_pkg::chan_vec_t pos_sync;
  lead_off_pkg::chan_vec_t neg_sync;
  lead_off_pkg::chan_vec_t chan_mask_ff;
  lead_off_pkg::variant_t variant_ff;
  logic strap_done_ff;
  logic [1:0] irq_status_ff;
  logic [1:0] irq_mask_ff;
  logic [1:0] irq_event;
  lead_off_pkg::chan_vec_t nxt_rdata;

  // Comparator outputs come from the analog side
  pin_sync3 u_sync_pos (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_async(i_pos_comp_off),
    .o_stable(pos_sync)
  );
  pin_sync3 u_sync_neg (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_async(i_neg_comp_off),
    .o_stable(neg_sync)
  );

  // Variant strap is caught once after reset release
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_done_ff <= 1'b0;
      variant_ff <= lead_off_pkg::VAR_8CH;
      chan_mask_ff <= `LO_MASK_8CH;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      unique case (i_variant)
        2'h0: begin
          variant_ff <= lead_off_pkg::VAR_4CH;
          chan_mask_ff <= `LO_MASK_4CH;
        end
        2'h1: begin
          variant_ff <= lead_off_pkg::VAR_6CH;
          chan_mask_ff <= `LO_MASK_6CH;
        end
        default: begin
          variant_ff <= lead_off_pkg::VAR_8CH;
          chan_mask_ff <= `LO_MASK_8CH;
        end
      endcase
    end
  end

  // Enable and polarity registers
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      positive_detect_enables_ff <= `LO_RST_REG;
      negative_detect_enables_ff <= `LO_RST_REG;
      excitation_polarity_bits_ff <= `LO_RST_REG;
    end else begin
      if (i_wr && i_addr == `LO_OFS_POS_ENABLE) begin
        positive_detect_enables_ff <= i_wdata & chan_mask_ff;
      end
      if (i_wr && i_addr == `LO_OFS_NEG_ENABLE) begin
        negative_detect_enables_ff <= i_wdata & chan_mask_ff;
      end
      if (i_wr && i_addr == `LO_OFS_POLARITY) begin
        excitation_polarity_bits_ff <= i_wdata;
      end
    end
  end

  // Status follows the detectors only; bus writes never reach it
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      positive_electrode_off_status_ff <= `LO_RST_REG;
      negative_electrode_off_status_ff <= `LO_RST_REG;
    end else begin
      positive_electrode_off_status_ff <= pos_sync & chan_mask_ff;
      negative_electrode_off_status_ff <= neg_sync & chan_mask_ff;
    end
  end

  // Excitation drive per channel
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_chan
      always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
          o_pos_pull_up[g] <= 1'b0;
          o_pos_pull_down[g] <= 1'b0;
          o_neg_pull_up[g] <= 1'b0;
          o_neg_pull_down[g] <= 1'b0;
        end else begin
          o_pos_pull_up[g] <= positive_detect_enables_ff[g] && !excitation_polarity_bits_ff[g];
          o_pos_pull_down[g] <= positive_detect_enables_ff[g] && excitation_polarity_bits_ff[g];
          o_neg_pull_down[g] <= negative_detect_enables_ff[g] && !excitation_polarity_bits_ff[g];
          o_neg_pull_up[g] <= negative_detect_enables_ff[g] && excitation_polarity_bits_ff[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pos_excite_en <= `LO_RST_REG;
      o_neg_excite_en <= `LO_RST_REG;
    end else begin
      o_pos_excite_en <= positive_detect_enables_ff;
      o_neg_excite_en <= negative_detect_enables_ff;
    end
  end

  // A lead drop counts only on channels whose detection is enabled
  assign irq_event[`LO_IRQ_POS_BIT] = |(pos_sync & chan_mask_ff & positive_detect_enables_ff
    & ~positive_electrode_off_status_ff);
  assign irq_event[`LO_IRQ_NEG_BIT] = |(neg_sync & chan_mask_ff & negative_detect_enables_ff
    & ~negative_electrode_off_status_ff);

  // Sticky status, write one to clear, a new event wins
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_status_ff <= 2'h0;
      irq_mask_ff <= 2'h0;
      o_irq <= 1'b0;
    end else begin
      if (i_wr && i_addr == `LO_OFS_IRQ_STATUS) begin
        irq_status_ff <= (irq_status_ff & ~i_wdata[1:0]) | irq_event;
      end else begin
        irq_status_ff <= irq_status_ff | irq_event;
      end
      if (i_wr && i_addr == `LO_OFS_IRQ_MASK) begin
        irq_mask_ff <= i_wdata[1:0];
      end
      o_irq <= |(irq_status_ff & irq_mask_ff);
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        `LO_OFS_POS_ENABLE: nxt_rdata = positive_detect_enables_ff;
        `LO_OFS_NEG_ENABLE: nxt_rdata = negative_detect_enables_ff;
        `LO_OFS_POLARITY: nxt_rdata = excitation_polarity_bits_ff;
        `LO_OFS_POS_STATUS: nxt_rdata = positive_electrode_off_status_ff;
        `LO_OFS_NEG_STATUS: nxt_rdata = negative_electrode_off_status_ff;
        `LO_OFS_IRQ_STATUS: nxt_rdata = {6'h00, irq_status_ff};
        `LO_OFS_IRQ_MASK: nxt_rdata = {6'h00, irq_mask_ff};
        `LO_OFS_VARIANT: nxt_rdata = {6'h00, variant_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= nxt_rdata;
    end
  end

  a_neg_en_reset: assert property (@(posedge i_clk_sys)
    $rose(i_arst_n) |-> negative_detect_enables_ff == 8'h00)
    else $error("negative enables not zero after reset");

  a_neg_en_write: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_wr && i_addr == `LO_OFS_NEG_ENABLE
      |=> negative_detect_enables_ff == ($past(i_wdata) & $past(chan_mask_ff)))
    else $error("negative enable write lost");

  a_variant_mask: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    variant_ff == lead_off_pkg::VAR_4CH |-> negative_detect_enables_ff[7:4] == 4'h0)
    else $error("unimplemented enable bits set");

  a_polarity_write: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_wr && i_addr == `LO_OFS_POLARITY |=> excitation_polarity_bits_ff == $past(i_wdata))
    else $error("polarity write lost");

  a_pull_normal: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    negative_detect_enables_ff[0] && !excitation_polarity_bits_ff[0] |=> o_neg_pull_down[0])
    else $error("normal polarity pull wrong");

  a_pull_flipped: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    positive_detect_enables_ff[0] && excitation_polarity_bits_ff[0]
      |=> o_pos_pull_down[0] && !o_pos_pull_up[0])
    else $error("flipped polarity pull wrong");

  a_pos_status_rd: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_rd && i_addr == `LO_OFS_POS_STATUS |=> o_rdata == $past(positive_electrode_off_status_ff))
    else $error("positive status read wrong");

  a_status_no_write: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_wr && i_addr == `LO_OFS_POS_STATUS && $stable(pos_sync)
      |=> $stable(positive_electrode_off_status_ff))
    else $error("status changed by write");

  a_neg_status: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    ##1 negative_electrode_off_status_ff == ($past(neg_sync) & $past(chan_mask_ff)))
    else $error("negative status mismatch");

  a_pol_reset: assert property (@(posedge i_clk_sys)
    $rose(i_arst_n) |-> excitation_polarity_bits_ff == `LO_RST_REG)
    else $error("polarity bits not zero after reset");

  a_pos_stat_reset: assert property (@(posedge i_clk_sys)
    $rose(i_arst_n) |-> positive_electrode_off_status_ff == `LO_RST_REG)
    else $error("positive status not zero after reset");

  a_pos_en_write: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_wr && i_addr == `LO_OFS_POS_ENABLE
      |=> positive_detect_enables_ff == ($past(i_wdata) & $past(chan_mask_ff)))
    else $error("positive enable write lost");

  a_six_ch_mask: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    variant_ff == lead_off_pkg::VAR_6CH |-> negative_detect_enables_ff[7:6] == 2'h0)
    else $error("six channel enable bits set");

  a_en_within_mask: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    ((negative_detect_enables_ff | positive_detect_enables_ff) & ~chan_mask_ff) == 8'h00)
    else $error("enable set on absent channel");

  a_neg_pull_flip: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    negative_detect_enables_ff[0] && excitation_polarity_bits_ff[0]
      |=> o_neg_pull_up[0] && !o_neg_pull_down[0])
    else $error("flipped negative pull wrong");

  a_pos_pull_norm: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    positive_detect_enables_ff[0] && !excitation_polarity_bits_ff[0]
      |=> o_pos_pull_up[0] && !o_pos_pull_down[0])
    else $error("normal positive pull wrong");

  a_pull_idle: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !negative_detect_enables_ff[0] |=> !o_neg_pull_up[0] && !o_neg_pull_down[0])
    else $error("pull active on disabled channel");

  a_excite_copy: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    1'b1 |=> o_neg_excite_en == $past(negative_detect_enables_ff))
    else $error("negative excitation enable wrong");

  a_pos_status_track: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    1'b1 |=> positive_electrode_off_status_ff == ($past(pos_sync) & $past(chan_mask_ff)))
    else $error("positive status mismatch");

  a_neg_stat_rd: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_rd && i_addr == `LO_OFS_NEG_STATUS |=> o_rdata == $past(negative_electrode_off_status_ff))
    else $error("negative status read wrong");

  a_pol_read: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_rd && i_addr == `LO_OFS_POLARITY |=> o_rdata == $past(excitation_polarity_bits_ff))
    else $error("polarity read wrong");

  a_neg_en_read: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_rd && i_addr == `LO_OFS_NEG_ENABLE |=> o_rdata == $past(negative_detect_enables_ff))
    else $error("negative enable read wrong");

  a_neg_en_hold: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !(i_wr && i_addr == `LO_OFS_NEG_ENABLE) |=> $stable(negative_detect_enables_ff))
    else $error("negative enables changed without write");

  a_pol_hold: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !(i_wr && i_addr == `LO_OFS_POLARITY) |=> $stable(excitation_polarity_bits_ff))
    else $error("polarity changed without write");

  a_pos_en_hold: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !(i_wr && i_addr == `LO_OFS_POS_ENABLE) |=> $stable(positive_detect_enables_ff))
    else $error("positive enables changed without write");

  a_neg_stat_ro: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_wr && i_addr == `LO_OFS_NEG_STATUS && $stable(neg_sync)
      |=> $stable(negative_electrode_off_status_ff))
    else $error("negative status changed by write");
endmodule : lead_off_register_bank
`default_nettype wire

// *** bench/electrode_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module electrode_model (
  input wire logic [7:0] i_pos_detached,
  input wire logic [7:0] i_neg_detached,
  input wire logic [7:0] i_pos_pull_up,
  input wire logic [7:0] i_pos_pull_down,
  input wire logic [7:0] i_neg_pull_up,
  input wire logic [7:0] i_neg_pull_down,
  output logic [7:0] o_pos_comp_off,
  output logic [7:0] o_neg_comp_off
);
  // A loose lead drifts with whichever pull is applied; an attached one stays put
  assign o_pos_comp_off = i_pos_detached & (i_pos_pull_up | i_pos_pull_down);
  assign o_neg_comp_off = i_neg_detached & (i_neg_pull_up | i_neg_pull_down);
endmodule : electrode_model
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "lead_off_defs.svh"
module testbench;
  logic i_clk_sys, i_arst_n, i_wr, i_rd;
  logic [7:0] i_addr, i_wdata, pos_det, neg_det, rdata;
  logic [1:0] i_variant;
  wire logic [7:0] pos_off, neg_off, o_rdata, pe, ne, pu, pd, nu, nd;
  wire logic o_irq;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;

  lead_off_register_bank DUT (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_variant(i_variant),
    .i_pos_comp_off(pos_off), .i_neg_comp_off(neg_off), .o_rdata(o_rdata),
    .o_pos_excite_en(pe), .o_neg_excite_en(ne), .o_pos_pull_up(pu), .o_pos_pull_down(pd),
    .o_neg_pull_up(nu), .o_neg_pull_down(nd), .o_irq(o_irq));
  electrode_model u_leads (.i_pos_detached(pos_det), .i_neg_detached(neg_det),
    .i_pos_pull_up(pu), .i_pos_pull_down(pd), .i_neg_pull_up(nu), .i_neg_pull_down(nd),
    .o_pos_comp_off(pos_off), .o_neg_comp_off(neg_off));

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  task report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      $display("ERROR %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 rdata = o_rdata;
  endtask : rd

  task do_reset(input lead_off_pkg::variant_t v);
    @(posedge i_clk_sys);
    i_arst_n <= 1'b0;
    i_variant <= v;
    repeat (5) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
  endtask : do_reset

  task t_reset_values;
    rd(`LO_OFS_NEG_ENABLE); chk(rdata, 8'h00);
    rd(`LO_OFS_POLARITY); chk(rdata, 8'h00);
    rd(`LO_OFS_POS_STATUS); chk(rdata, 8'h00);
    rd(8'h40); chk(rdata, 8'h00);
    chk(ne | pe, 8'h00);
    chk(pu | pd | nu | nd, 8'h00);
    $display("test reset values done");
  endtask : t_reset_values

  task t_enables_pulls;
    wr(`LO_OFS_NEG_ENABLE, 8'hff);
    repeat (3) @(posedge i_clk_sys);
    chk(ne, 8'hff);
    chk(nd, 8'hff);
    chk(nu | pu | pd, 8'h00);
    wr(`LO_OFS_POLARITY, 8'ha5);
    wr(`LO_OFS_POS_ENABLE, 8'hff);
    rd(`LO_OFS_POLARITY); chk(rdata, 8'ha5);
    @(posedge i_clk_sys);
    #1 chk(o_rdata, 8'h00);
    repeat (3) @(posedge i_clk_sys);
    chk(pe, 8'hff);
    chk(pu, 8'h5a);
    chk(pd, 8'ha5);
    chk(nu, 8'ha5);
    chk(nd, 8'h5a);
    wr(`LO_OFS_POLARITY, 8'h00);
    rd(`LO_OFS_NEG_ENABLE); chk(rdata, 8'hff);
    $display("test enables and pulls done");
  endtask : t_enables_pulls

  task t_status_irq;
    @(posedge i_clk_sys);
    pos_det <= 8'h81;
    neg_det <= 8'h02;
    repeat (10) @(posedge i_clk_sys);
    rd(`LO_OFS_POS_STATUS); chk(rdata, 8'h81);
    wr(`LO_OFS_POS_STATUS, 8'h00);
    rd(`LO_OFS_POS_STATUS); chk(rdata, 8'h81);
    rd(`LO_OFS_NEG_STATUS); chk(rdata, 8'h02);
    rd(`LO_OFS_IRQ_STATUS); chk(rdata, 8'h03);
    chk({7'h00, o_irq}, 8'h00);
    wr(`LO_OFS_IRQ_MASK, 8'h01);
    repeat (2) @(posedge i_clk_sys);
    chk({7'h00, o_irq}, 8'h01);
    wr(`LO_OFS_IRQ_STATUS, 8'h03);
    repeat (2) @(posedge i_clk_sys);
    chk({7'h00, o_irq}, 8'h00);
    pos_det <= 8'h00;
    neg_det <= 8'h00;
    $display("test status and interrupt done");
  endtask : t_status_irq

  task t_variants;
    do_reset(lead_off_pkg::VAR_4CH);
    wr(`LO_OFS_NEG_ENABLE, 8'hff);
    wr(`LO_OFS_POS_ENABLE, 8'hff);
    rd(`LO_OFS_NEG_ENABLE); chk(rdata, 8'h0f);
    rd(`LO_OFS_POS_ENABLE); chk(rdata, 8'h0f);
    rd(`LO_OFS_VARIANT); chk(rdata, {6'h00, lead_off_pkg::VAR_4CH});
    do_reset(lead_off_pkg::VAR_6CH);
    wr(`LO_OFS_NEG_ENABLE, 8'hff);
    rd(`LO_OFS_NEG_ENABLE); chk(rdata, 8'h3f);
    rd(`LO_OFS_VARIANT); chk(rdata, {6'h00, lead_off_pkg::VAR_6CH});
    $display("test variants done");
  endtask : t_variants

  initial begin
    i_arst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    pos_det = 8'h00;
    neg_det = 8'h00;
    i_variant = lead_off_pkg::VAR_8CH;
    do_reset(lead_off_pkg::VAR_8CH);
    t_reset_values();
    t_enables_pulls();
    t_status_irq();
    t_variants();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
